// *** inc/cio_pkg.sv ***
package cio_pkg;

    localparam int          EXF_W         = 15;
    localparam int          CODE_W        = 12;
    localparam int          WORD_W        = 48;
    localparam int          CHAR_W        = 6;
    localparam int          NCHAR         = 8;
    localparam int          RDR_W         = 8;
    localparam int          CNT_W         = 3;
    localparam logic [2:0]  CHAR0         = 3'h0;
    localparam logic [2:0]  CHAR_FIRST    = 3'h7;
    localparam int          CTRL_LEVEL    = 6;

    // Channel two codes carry a leading 2 in their top octal digit.
    localparam logic [11:0] CH1_KBD_PFX   = 12'h049;
    localparam logic [5:0]  PFX_KBD       = 6'h09;
    localparam logic [5:0]  PFX_RDR       = 6'h0A;
    localparam logic [2:0]  CH1_TOP       = 3'h1;
    localparam logic [2:0]  CH2_TOP       = 3'h2;

    localparam logic [11:0] SEL_KBD_NOCR  = 12'h240;
    localparam logic [11:0] SEL_KBD_CR    = 12'h260;
    localparam logic [11:0] SEL_RDR_EOTI  = 12'h280;
    localparam logic [11:0] SEL_RDR_EOT   = 12'h288;
    localparam logic [11:0] SEL_RDR_NOI   = 12'h290;
    localparam logic [11:0] SEL_PRN_ASM   = 12'h240;
    localparam logic [11:0] SEL_PRN_CHR   = 12'h248;
    localparam logic [11:0] SEL_PUN_ASM   = 12'h280;
    localparam logic [11:0] SEL_PUN_CHR   = 12'h288;
    localparam logic [11:0] SEL_PUN_OFF   = 12'h2A0;

    localparam logic [11:0] SNS_KBD_CR    = 12'h240;
    localparam logic [11:0] SNS_KBD_CASE  = 12'h260;
    localparam logic [11:0] SNS_RDR_EOT   = 12'h280;
    localparam logic [11:0] SNS_RDR_MODE  = 12'h288;
    localparam logic [11:0] SNS_PUN_OOT   = 12'h280;

endpackage : cio_pkg

// *** design/cio_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module cio_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            q_o      <= '0;
        end else begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end
endmodule : cio_sync
`default_nettype wire

// *** design/cio_distributor.sv ***
`timescale 1ns/1ps
`default_nettype none
module cio_distributor (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    input  wire logic        master_clear_i,
    input  wire logic [14:0] external_function_code_i,
    input  wire logic        function_ready_i,
    input  wire logic        sense_i,
    output logic             sense_return_gate_o,
    input  wire logic        kbd_cr_tab_i,
    input  wire logic        kbd_lower_case_i,
    input  wire logic        punch_out_of_tape_i,
    input  wire logic        reader_motor_switch_i,
    input  wire logic        reader_mode_switch_i,
    input  wire logic        reader_feed_i,
    input  wire logic [7:0]  reader_char_i,
    input  wire logic        kbd_strobe_i,
    input  wire logic [5:0]  kbd_char_i,
    input  wire logic        in_resume_i,
    output logic [47:0]      input_word_o,
    output logic             in_ready_o,
    input  wire logic        out_ready_i,
    input  wire logic [47:0] out_word_i,
    input  wire logic        out_timing_i,
    output logic [7:0]       out_char_o,
    output logic             out_strobe_o,
    output logic             out_resume_o,
    output logic             reader_select_flag_o,
    output logic             punch_select_flag_o,
    output logic             keyboard_select_flag_o,
    output logic             printer_select_flag_o,
    output logic             carriage_return_interrupt_flag_o,
    output logic             end_of_tape_flag_o,
    output logic             end_of_tape_interrupt_flag_o,
    output logic             assembly_mode_flag_o,
    output logic             punch_motor_flag_o,
    output logic             reader_motor_flag_o,
    output logic             reader_clutch_o,
    output logic             load_point_seek_o
);
    typedef enum logic [1:0] {CIO_IDLE, CIO_WAIT, CIO_HOLD} cio_out_state_t;

    logic [4:0]  pin_sync;
    logic [7:0]  rdr_char_sync;
    logic [5:0]  kbd_char_sync;
    logic        feed_s;
    logic        kbd_s;
    logic        timing_s;
    logic        motor_sw_s;
    logic        feed_d_reg;
    logic        kbd_d_reg;
    logic        timing_d_reg;
    logic        feed_pulse;
    logic        kbd_pulse;
    logic        timing_pulse;
    logic [11:0] code;
    logic [2:0]  chan_top;
    logic        ch1;
    logic        ch2;
    logic        sel;
    logic        mode_sel;
    logic [47:0] input_assembly_register;
    logic [2:0]  asm_cnt_reg;
    logic [47:0] output_word_register;
    logic [2:0]  dis_cnt_reg;
    logic        reader_char_mode;
    logic        sense_hit;
    logic [5:0]  out_slot;
    logic [47:0] char_word;
    cio_out_state_t out_state_reg;

    cio_sync #(.W(5)) u_sync_ctl (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .d_i       ({reader_mode_switch_i, reader_feed_i, kbd_strobe_i, out_timing_i,
                     reader_motor_switch_i}),
        .q_o       (pin_sync)
    );
    cio_sync #(.W(14)) u_sync_dat (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .d_i       ({reader_char_i, kbd_char_i}),
        .q_o       ({rdr_char_sync, kbd_char_sync})
    );

    assign feed_s     = pin_sync[3];
    assign kbd_s      = pin_sync[2];
    assign timing_s   = pin_sync[1];
    assign motor_sw_s = pin_sync[0];

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            feed_d_reg   <= 1'b0;
            kbd_d_reg    <= 1'b0;
            timing_d_reg <= 1'b0;
        end else begin
            feed_d_reg   <= feed_s;
            kbd_d_reg    <= kbd_s;
            timing_d_reg <= timing_s;
        end
    end
    assign feed_pulse   = feed_s & ~feed_d_reg;
    assign kbd_pulse    = kbd_s & ~kbd_d_reg;
    assign timing_pulse = timing_s & ~timing_d_reg;

    assign code     = external_function_code_i[cio_pkg::CODE_W-1:0];
    assign chan_top = external_function_code_i[14:12];
    assign ch1      = (chan_top == cio_pkg::CH1_TOP);
    assign ch2      = (chan_top == cio_pkg::CH2_TOP);
    assign sel      = function_ready_i & ~sense_i;
    assign mode_sel = sel & ((ch1 & (code[11:6] == cio_pkg::PFX_RDR))
                           | (ch2 & (code[11:6] != 6'h00)));

    // Translator flags: master clear dominates any code decoded alongside it.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || master_clear_i) begin
            reader_select_flag_o             <= 1'b1;
            keyboard_select_flag_o           <= 1'b0;
            punch_select_flag_o              <= 1'b0;
            printer_select_flag_o            <= 1'b0;
            carriage_return_interrupt_flag_o <= 1'b0;
            end_of_tape_interrupt_flag_o     <= 1'b0;
            assembly_mode_flag_o             <= 1'b0;
            punch_motor_flag_o               <= 1'b0;
        end else if (sel && ch1) begin
            case (code)
                cio_pkg::SEL_KBD_NOCR: begin
                    keyboard_select_flag_o           <= 1'b1;
                    reader_select_flag_o             <= 1'b0;
                    carriage_return_interrupt_flag_o <= 1'b0;
                end
                cio_pkg::SEL_KBD_CR: begin
                    keyboard_select_flag_o           <= 1'b1;
                    reader_select_flag_o             <= 1'b0;
                    carriage_return_interrupt_flag_o <= 1'b1;
                end
                cio_pkg::SEL_RDR_EOTI: begin
                    reader_select_flag_o         <= 1'b1;
                    keyboard_select_flag_o       <= 1'b0;
                    end_of_tape_interrupt_flag_o <= 1'b1;
                end
                cio_pkg::SEL_RDR_EOT: begin
                    reader_select_flag_o         <= 1'b1;
                    keyboard_select_flag_o       <= 1'b0;
                    end_of_tape_interrupt_flag_o <= 1'b0;
                end
                cio_pkg::SEL_RDR_NOI: begin
                    reader_select_flag_o         <= 1'b1;
                    keyboard_select_flag_o       <= 1'b0;
                    end_of_tape_interrupt_flag_o <= 1'b0;
                end
                default: begin
                end
            endcase
        end else if (sel && ch2) begin
            case (code)
                cio_pkg::SEL_PRN_ASM, cio_pkg::SEL_PRN_CHR: begin
                    printer_select_flag_o <= 1'b1;
                    punch_select_flag_o   <= 1'b0;
                    assembly_mode_flag_o  <= (code == cio_pkg::SEL_PRN_ASM);
                end
                cio_pkg::SEL_PUN_ASM, cio_pkg::SEL_PUN_CHR: begin
                    punch_select_flag_o   <= 1'b1;
                    printer_select_flag_o <= 1'b0;
                    assembly_mode_flag_o  <= (code == cio_pkg::SEL_PUN_ASM);
                    punch_motor_flag_o    <= 1'b1;
                end
                cio_pkg::SEL_PUN_OFF: begin
                    punch_motor_flag_o <= 1'b0;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            reader_motor_flag_o <= 1'b0;
        end else begin
            reader_motor_flag_o <= motor_sw_s;
        end
    end

    // Mode switch low, once synchronised, selects reader character mode.
    assign reader_char_mode = ~pin_sync[4];

    always_ff @(posedge sys_clk_i) begin
        if (rst_i || master_clear_i) begin
            end_of_tape_flag_o <= 1'b0;
        end else if (sel && ch1 && code == cio_pkg::SEL_RDR_EOT) begin
            end_of_tape_flag_o <= 1'b1;
        end else if (feed_pulse && reader_select_flag_o && !reader_char_mode
                     && asm_cnt_reg == cio_pkg::CHAR_FIRST
                     && !rdr_char_sync[cio_pkg::CTRL_LEVEL]) begin
            end_of_tape_flag_o <= 1'b1;
        end else if (mode_sel) begin
            end_of_tape_flag_o <= 1'b0;
        end
    end

    // Reader clutch: assembly seeks the load point, character releases it for one clock after each feed pulse.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            load_point_seek_o <= 1'b0;
            reader_clutch_o   <= 1'b0;
        end else begin
            load_point_seek_o <= reader_motor_flag_o & reader_select_flag_o
                                 & ~reader_char_mode & ~end_of_tape_flag_o;
            reader_clutch_o   <= reader_motor_flag_o & reader_select_flag_o
                                 & ~end_of_tape_flag_o
                                 & (~reader_char_mode | ~feed_pulse);
        end
    end

    // Input distributor.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || !(reader_select_flag_o || keyboard_select_flag_o)) begin
            input_assembly_register <= '0;
            asm_cnt_reg             <= cio_pkg::CHAR_FIRST;
            in_ready_o              <= 1'b0;
        end else if (in_ready_o) begin
            if (in_resume_i) begin
                input_assembly_register <= '0;
                in_ready_o              <= 1'b0;
            end
        end else if (keyboard_select_flag_o && kbd_pulse) begin
            input_assembly_register <= {42'h0, kbd_char_sync};
            in_ready_o              <= 1'b1;
        end else if (reader_select_flag_o && feed_pulse && !end_of_tape_flag_o) begin
            if (reader_char_mode) begin
                asm_cnt_reg             <= cio_pkg::CHAR0;
                input_assembly_register <= {40'h0, rdr_char_sync};
                in_ready_o              <= 1'b1;
            end else if (asm_cnt_reg != cio_pkg::CHAR_FIRST
                         || rdr_char_sync[cio_pkg::CTRL_LEVEL]) begin
                input_assembly_register[asm_cnt_reg*cio_pkg::CHAR_W +: cio_pkg::CHAR_W]
                    <= rdr_char_sync[5:0];
                asm_cnt_reg <= asm_cnt_reg - 3'h1;
                in_ready_o  <= (asm_cnt_reg == cio_pkg::CHAR0);
            end
        end
    end
    assign input_word_o = input_assembly_register;

    // Output distributor.
    assign out_slot  = {dis_cnt_reg, 3'h0} - {2'h0, dis_cnt_reg, 1'b0};
    assign char_word = output_word_register >> out_slot;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            out_state_reg        <= CIO_IDLE;
            output_word_register <= '0;
            dis_cnt_reg          <= cio_pkg::CHAR_FIRST;
            out_char_o           <= 8'h00;
            out_strobe_o         <= 1'b0;
            out_resume_o         <= 1'b0;
        end else begin
            out_strobe_o <= 1'b0;
            case (out_state_reg)
                CIO_IDLE: begin
                    out_resume_o <= 1'b0;
                    if (out_ready_i && (punch_select_flag_o || printer_select_flag_o)) begin
                        output_word_register <= out_word_i;
                        dis_cnt_reg <= assembly_mode_flag_o ? cio_pkg::CHAR_FIRST
                                                            : cio_pkg::CHAR0;
                        out_state_reg <= CIO_WAIT;
                    end
                end
                CIO_WAIT: begin
                    if (timing_pulse) begin
                        out_strobe_o <= 1'b1;
                        if (assembly_mode_flag_o) begin
                            out_char_o  <= {2'h0, char_word[5:0]};
                            dis_cnt_reg <= dis_cnt_reg - 3'h1;
                        end else begin
                            out_char_o <= char_word[7:0];
                        end
                        if (!assembly_mode_flag_o || dis_cnt_reg == cio_pkg::CHAR0) begin
                            out_resume_o  <= 1'b1;
                            out_state_reg <= CIO_HOLD;
                        end
                    end
                end
                CIO_HOLD: begin
                    if (!out_ready_i) begin
                        out_resume_o  <= 1'b0;
                        out_state_reg <= CIO_IDLE;
                    end
                end
                default: out_state_reg <= CIO_IDLE;
            endcase
        end
    end

    // Sense gate: low bit of the code is not examined.
    always_comb begin
        sense_hit = 1'b0;
        if (ch1) begin
            case ({code[11:1], 1'b0})
                cio_pkg::SNS_KBD_CR:   sense_hit = kbd_cr_tab_i;
                cio_pkg::SNS_KBD_CASE: sense_hit = kbd_lower_case_i;
                cio_pkg::SNS_RDR_EOT:  sense_hit = end_of_tape_flag_o;
                cio_pkg::SNS_RDR_MODE: sense_hit = ~reader_char_mode;
                default:               sense_hit = 1'b0;
            endcase
        end else if (ch2) begin
            sense_hit = ({code[11:1], 1'b0} == cio_pkg::SNS_PUN_OOT)
                        & punch_out_of_tape_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            sense_return_gate_o <= 1'b0;
        end else begin
            sense_return_gate_o <= function_ready_i & sense_i & sense_hit;
        end
    end

endmodule : cio_distributor
`default_nettype wire

// *** testbench/cio_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module cio_monitor (
    input wire logic        sys_clk_i,
    input wire logic        rst_i,
    input wire logic        master_clear_i,
    input wire logic [14:0] external_function_code_i,
    input wire logic        function_ready_i,
    input wire logic        sense_i,
    input wire logic        sense_return_gate_o,
    input wire logic        kbd_cr_tab_i,
    input wire logic        punch_out_of_tape_i,
    input wire logic [47:0] input_word_o,
    input wire logic        in_ready_o,
    input wire logic [47:0] out_word_i,
    input wire logic        out_ready_i,
    input wire logic [7:0]  out_char_o,
    input wire logic        out_strobe_o,
    input wire logic        reader_select_flag_o,
    input wire logic        punch_select_flag_o,
    input wire logic        keyboard_select_flag_o,
    input wire logic        printer_select_flag_o,
    input wire logic        carriage_return_interrupt_flag_o,
    input wire logic        end_of_tape_flag_o,
    input wire logic        end_of_tape_interrupt_flag_o,
    input wire logic        assembly_mode_flag_o,
    input wire logic        punch_motor_flag_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    wire logic [14:0] code = external_function_code_i;
    wire logic        sel  = function_ready_i && !sense_i && !master_clear_i;
    wire logic        sns  = function_ready_i && sense_i;
    property p_rdr_sel;
        sel && code == 15'h1280 |=> reader_select_flag_o && !keyboard_select_flag_o;
    endproperty
    a_rdr_sel: assert property (p_rdr_sel) else $error("reader select");
    property p_prn_sel;
        sel && code == 15'h2240 |=> printer_select_flag_o && !punch_select_flag_o
            && assembly_mode_flag_o;
    endproperty
    a_prn_sel: assert property (p_prn_sel) else $error("printer select");
    property p_mclr;
        master_clear_i |=> reader_select_flag_o && !keyboard_select_flag_o && !end_of_tape_flag_o;
    endproperty
    a_mclr: assert property (p_mclr) else $error("master clear");
    property p_hold;
        !function_ready_i && !master_clear_i |=> $stable({reader_select_flag_o,
            punch_select_flag_o, keyboard_select_flag_o, printer_select_flag_o,
            carriage_return_interrupt_flag_o, end_of_tape_interrupt_flag_o,
            assembly_mode_flag_o, punch_motor_flag_o});
    endproperty
    a_hold: assert property (p_hold) else $error("flag moved");
    property p_cri;
        sel && code == 15'h1260 |=> carriage_return_interrupt_flag_o && keyboard_select_flag_o;
    endproperty
    a_cri: assert property (p_cri) else $error("CR interrupt select");
    property p_eot;
        sel && code == 15'h1288 |=> end_of_tape_flag_o;
    endproperty
    a_eot: assert property (p_eot) else $error("end of tape not set");
    property p_motor_off;
        sel && code == 15'h22A0 |=> !punch_motor_flag_o;
    endproperty
    a_motor_off: assert property (p_motor_off) else $error("punch motor on");
    property p_sns_cr;
        sns && code[14:1] == 14'h0920 |=> sense_return_gate_o == $past(kbd_cr_tab_i);
    endproperty
    a_sns_cr: assert property (p_sns_cr) else $error("CR sense");
    property p_sns_pun;
        sns && code[14:1] == 14'h1140 |=> sense_return_gate_o == $past(punch_out_of_tape_i);
    endproperty
    a_sns_pun: assert property (p_sns_pun) else $error("punch sense");
    property p_ar_idle;
        (!reader_select_flag_o && !keyboard_select_flag_o) [*2] |-> input_word_o == 48'h0;
    endproperty
    a_ar_idle: assert property (p_ar_idle) else $error("word not clear");
    property p_kbd_word;
        in_ready_o && keyboard_select_flag_o |-> input_word_o[47:6] == 42'h0;
    endproperty
    a_kbd_word: assert property (p_kbd_word) else $error("keyboard high bits");
    property p_chr_out;
        out_strobe_o && !assembly_mode_flag_o && out_ready_i |-> out_char_o == out_word_i[7:0];
    endproperty
    a_chr_out: assert property (p_chr_out) else $error("character output");
    property p_strobe;
        out_strobe_o |=> !out_strobe_o;
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe too long");
    c_kbd: cover property (in_ready_o && keyboard_select_flag_o);
    c_out: cover property (out_strobe_o && assembly_mode_flag_o);
    c_sns: cover property (sense_return_gate_o);
endmodule : cio_monitor
bind cio_distributor cio_monitor i_cio_monitor (.*);
`default_nettype wire

// *** testbench/cio_cpu_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module cio_cpu_model (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    input  wire logic        in_ready_i,
    input  wire logic [3:0]  delay_i,
    output logic             in_resume_o,
    input  wire logic        load_i,
    input  wire logic [47:0] word_i,
    input  wire logic        out_resume_i,
    output logic             out_ready_o,
    output logic [47:0]      out_word_o
);
    logic [3:0] wait_reg;
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || !in_ready_i) begin
            wait_reg    <= 4'h0;
            in_resume_o <= 1'b0;
        end else if (wait_reg >= delay_i) begin
            in_resume_o <= 1'b1;
        end else begin
            wait_reg <= wait_reg + 4'h1;
        end
    end
    // Invert a released word so stale data cannot pass.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            out_ready_o <= 1'b0;
            out_word_o  <= 48'h0;
        end else if (load_i) begin
            out_ready_o <= 1'b1;
            out_word_o  <= word_i;
        end else if (out_ready_o && out_resume_i) begin
            out_ready_o <= 1'b0;
            out_word_o  <= ~out_word_o;
        end
    end
endmodule : cio_cpu_model
`default_nettype wire

// *** testbench/cio_distributor_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module cio_distributor_tb;
    logic        sys_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        mclr = 1'b0, fr = 1'b0, sns = 1'b0, cr_tab = 1'b0, lower = 1'b0, oot = 1'b0;
    logic        motor_sw = 1'b0, mode_sw = 1'b1, ld = 1'b0;
    logic [14:0] code = 15'h0;
    logic [2:0]  pins = 3'h0;
    logic [7:0]  rchar = 8'h0;
    logic [5:0]  kchar = 6'h0;
    logic [3:0]  delay = 4'h0;
    logic [47:0] ld_word = 48'h0, in_word, out_word, exp;
    logic        in_resume, in_ready, out_ready, out_strobe, out_resume, sret;
    logic        f_rdr, f_pun, f_kbd, f_prn, f_cri, f_eot, f_eoti, f_asm, f_pmot, f_rmot;
    logic [7:0]  out_char;
    logic [8:0]  snap;
    logic [7:0]  seen_q[$];
    int          compares = 0;
    int          n_mismatch = 0;
    logic [14:0] sc [10] = '{15'h1260, 15'h1240, 15'h1288, 15'h1280, 15'h1290, 15'h2280,
                             15'h2240, 15'h2248, 15'h2288, 15'h22A0};
    logic [8:0]  sv [10] = '{9'h050, 9'h040, 9'h108, 9'h104, 9'h100, 9'h083, 9'h022, 9'h020,
                             9'h081, 9'h080};
    logic [8:0]  sm [10] = '{9'h150, 9'h150, 9'h148, 9'h10C, 9'h104, 9'h0AB, 9'h0A2, 9'h022,
                             9'h0A3, 9'h083};
    logic [14:0] sn [5] = '{15'h1240, 15'h1260, 15'h1280, 15'h1288, 15'h2280};
    always #12.5 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        if (out_strobe) begin
            seen_q.push_back(out_char);
        end
    end
    cio_distributor i_cio_distributor (.sys_clk_i, .rst_i,
        .master_clear_i(mclr), .external_function_code_i(code), .function_ready_i(fr),
        .sense_i(sns), .sense_return_gate_o(sret), .kbd_cr_tab_i(cr_tab),
        .kbd_lower_case_i(lower), .punch_out_of_tape_i(oot), .reader_motor_switch_i(motor_sw),
        .reader_mode_switch_i(mode_sw), .reader_feed_i(pins[0]), .reader_char_i(rchar),
        .kbd_strobe_i(pins[1]), .kbd_char_i(kchar), .in_resume_i(in_resume),
        .input_word_o(in_word), .in_ready_o(in_ready), .out_ready_i(out_ready),
        .out_word_i(out_word), .out_timing_i(pins[2]), .out_char_o(out_char),
        .out_strobe_o(out_strobe), .out_resume_o(out_resume), .reader_select_flag_o(f_rdr),
        .punch_select_flag_o(f_pun), .keyboard_select_flag_o(f_kbd),
        .printer_select_flag_o(f_prn), .carriage_return_interrupt_flag_o(f_cri),
        .end_of_tape_flag_o(f_eot), .end_of_tape_interrupt_flag_o(f_eoti),
        .assembly_mode_flag_o(f_asm), .punch_motor_flag_o(f_pmot),
        .reader_motor_flag_o(f_rmot), .reader_clutch_o(), .load_point_seek_o());
    cio_cpu_model i_cio_cpu_model (.sys_clk_i, .rst_i, .in_ready_i(in_ready),
        .delay_i(delay), .in_resume_o(in_resume), .load_i(ld), .word_i(ld_word),
        .out_resume_i(out_resume), .out_ready_o(out_ready), .out_word_o(out_word));
    task stop_test;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test
    task chk(input logic [47:0] seen, input logic [47:0] want);
        compares++;
        if (seen !== want) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, want);
        end
    endtask : chk
    task chkf(input logic [8:0] want, input logic [8:0] mask);
        chk({39'h0, {f_rdr, f_pun, f_kbd, f_prn, f_cri, f_eot, f_eoti, f_asm, f_pmot} & mask},
            {39'h0, want});
    endtask : chkf
    task func(input logic [14:0] c, input logic s);
        @(negedge sys_clk_i);
        code = c;
        sns  = s;
        fr   = 1'b1;
        @(negedge sys_clk_i);
        fr = 1'b0;
    endtask : func
    task pulse(input int k);
        pins[k] = 1'b1;
        repeat (6) @(negedge sys_clk_i);
        pins[k] = 1'b0;
        repeat (6) @(negedge sys_clk_i);
    endtask : pulse
    task in_char(input int k, input logic last, input logic [47:0] want);
        if (last) begin
            pins[k] = 1'b1;
            for (int n = 0; in_ready !== 1'b1; n++) begin
                if (n > 40) begin
                    n_mismatch++;
                    stop_test();
                end
                @(negedge sys_clk_i);
            end
            chk(in_word, want);
        end
        pulse(k);
        if (!last) begin
            chk({47'h0, in_ready}, 48'h0);
        end
    endtask : in_char
    task load(input logic [47:0] w);
        ld_word = w;
        ld = 1'b1;
        @(negedge sys_clk_i);
        ld = 1'b0;
        repeat (2) @(negedge sys_clk_i);
    endtask : load
    initial begin
        repeat (3) @(negedge sys_clk_i);
        rst_i = 1'b0;
        chkf(9'h100, 9'h1FF);
        motor_sw = 1'b1;
        repeat (5) @(negedge sys_clk_i);
        chk({47'h0, f_rmot}, 48'h1);
        $display("test reset done");
        for (int i = 0; i < 10; i++) begin
            func(sc[i], 1'b0);
            chkf(sv[i], sm[i]);
        end
        snap = {f_rdr, f_pun, f_kbd, f_prn, f_cri, f_eot, f_eoti, f_asm, f_pmot};
        func(15'h12C0, 1'b0);
        chkf(snap, 9'h1FF);
        func(15'h3240, 1'b0);
        chkf(snap, 9'h1FF);
        code = 15'h1240;
        repeat (2) @(negedge sys_clk_i);
        chkf(snap, 9'h1FF);
        mclr = 1'b1;
        func(15'h1240, 1'b0);
        mclr = 1'b0;
        chkf(9'h100, 9'h1FF);
        $display("test select done");
        for (int i = 0; i < 5; i++) begin
            for (int c = 0; c < 2; c++) begin
                case (i)
                    0: cr_tab = c[0];
                    1: lower = c[0];
                    2: func(c[0] ? 15'h1288 : 15'h1280, 1'b0);
                    3: begin
                        mode_sw = c[0];
                        @(negedge sys_clk_i);
                    end
                    default: oot = c[0];
                endcase
                func(sn[i], 1'b1);
                chk({47'h0, sret}, {47'h0, c[0]});
                func(sn[i] | 15'h0001, 1'b1);
                chk({47'h0, sret}, {47'h0, c[0]});
            end
        end
        $display("test sense done");
        func(15'h1240, 1'b0);
        kchar = 6'h2D;
        in_char(1, 1'b1, 48'h2D);
        kchar = 6'h3F;
        in_char(1, 1'b1, 48'h3F);
        $display("test keyboard done");
        mode_sw = 1'b1;
        delay = 4'h9;
        func(15'h1280, 1'b0);
        rchar = 8'h05;
        in_char(0, 1'b0, 48'h0);
        chk({47'h0, f_eot}, 48'h1);
        func(15'h1290, 1'b0);
        chk({47'h0, f_eot}, 48'h0);
        exp = 48'h0;
        for (int k = 0; k < 8; k++) begin
            rchar = {1'b0, k == 0, 6'(k * 11 + 5)};
            exp = {exp[41:0], rchar[5:0]};
            in_char(0, k == 7, exp);
        end
        mode_sw = 1'b0;
        rchar = 8'hC5;
        in_char(0, 1'b1, 48'hC5);
        $display("test reader done");
        func(15'h2280, 1'b0);
        seen_q.delete();
        load(48'hF1E2D3C4B5A6);
        repeat (8) pulse(2);
        chk(48'(seen_q.size()), 48'h8);
        for (int i = 0; i < 8; i++) begin
            chk({42'h0, seen_q[i][5:0]}, {42'h0, ld_word[47 - 6 * i -: 6]});
        end
        chk({47'h0, out_ready}, 48'h0);
        func(15'h2288, 1'b0);
        seen_q.delete();
        load(48'h123456789A9C);
        pulse(2);
        chk(48'(seen_q.size()), 48'h1);
        chk({40'h0, seen_q[0]}, 48'h9C);
        chk({47'h0, out_ready}, 48'h0);
        $display("test output done");
        stop_test();
    end
endmodule : cio_distributor_tb
`default_nettype wire
